// [rtl/swkf_field_cmp.sv]
`timescale 1ns/1ps
// masked compare of one field; a disabled field always agrees
module swkf_field_cmp #(
    parameter int W = 8
) (
    input wire logic [W-1:0] rx_i, // received value
    input wire logic [W-1:0] exp_i, // expected value
    input wire logic [W-1:0] mask_i, // one = bit compared
    input wire logic en_i, // field takes part in the compare
    output logic match_o // field agrees
);
    // only unmasked bits (mask zero) may differ
    assign match_o = !en_i || (((rx_i ^ exp_i) & mask_i) == '0);
endmodule // swkf_field_cmp

// [rtl/swkf_filter_cfg.sv]
`timescale 1ns/1ps
// Overview of operation
// - mask byte for identifier bits 20 to 13
// - mask byte for identifier bits 12 to 5
// - identifier bits 4..0 mask at bits 6:2
// - reserved bits always read back zero
// - four-bit length code at bits 3:0
// - length code zero means empty payload
// - codes eight to fifteen mean eight bytes
// - length code must match all four bits
// - expected data byte seven register
// - expected data byte six register
// - power-on or soft reset clears all fields
// - valid flag cleared on wake, reset, change
module swkf_filter_cfg (
    input wire logic clk_sys_i, // system clock, 100 MHz
    input wire logic nrst_i, // asynchronous power-on reset, active low
    input wire logic soft_rst_i, // soft reset pulse
    input wire swkf_pkg::swkf_reg_req_type reg_req_i, // register access
    output logic [7:0] rd_data_o, // read data, valid cycle after rd_en
    input wire logic cfg_valid_set_i, // host sets the valid flag
    input wire logic cfg_other_write_i, // write to other wake config regs
    input wire logic wake_event_i, // a wake-up has happened
    input wire logic [20:0] exp_id_i, // expected identifier bits 20..0
    input wire logic frame_valid_i, // received frame fields valid
    input wire swkf_pkg::swkf_rx_frame_type rx_frame_i, // received frame
    output logic config_valid_flag_o, // selective wake enabled
    output logic wake_frame_match_o // one-cycle match pulse
);
    import swkf_pkg::*;

    // configuration storage
    logic [7:0] mask_high_ff, nxt_mask_high; // id mask 20..13
    logic [7:0] mask_low_ff, nxt_mask_low; // id mask 12..5
    logic [4:0] mask_lowest_ff, nxt_mask_lowest; // id mask 4..0
    logic [3:0] dlc_ff, nxt_dlc; // expected length code
    logic [7:0] byte_seven_ff, nxt_byte_seven; // expected data byte 7
    logic [7:0] byte_six_ff, nxt_byte_six; // expected data byte 6
    // status and answer
    logic [7:0] rd_data_ff, nxt_rd_data; // held read answer
    logic flag_ff, nxt_flag; // configuration valid
    logic match_ff, nxt_match; // match pulse
    // combinational helpers
    logic wr_hit; // write landed on one of our registers
    logic [7:0] rd_mux; // read value before registering
    logic [SWKF_ID_W-1:0] id_mask; // assembled identifier mask
    logic id_ok, dlc_ok, b7_ok, b6_ok; // per-field agreement
    logic b7_en, b6_en; // byte covered by the length code

    // full identifier mask, bit 20 at the top
    assign id_mask = {mask_high_ff, mask_low_ff, mask_lowest_ff};

    // codes 8..15 all mean eight bytes, so byte seven needs dlc[3]
    assign b7_en = dlc_ff[SWKF_DLC_MSB];
    // byte six is present from seven bytes upward; code 0 covers none
    assign b6_en = dlc_ff[SWKF_DLC_MSB] || (dlc_ff == SWKF_DLC_SEVEN);

    // identifier compare, masked per bit
    swkf_field_cmp #(.W(SWKF_ID_W)) u_cmp_id (
        .rx_i(rx_frame_i.id),
        .exp_i(exp_id_i),
        .mask_i(id_mask),
        .en_i(1'b1),
        .match_o(id_ok)
    );

    // length code compared bit by bit, no equivalence of long codes
    swkf_field_cmp #(.W(4)) u_cmp_dlc (
        .rx_i(rx_frame_i.dlc),
        .exp_i(dlc_ff),
        .mask_i(4'hf),
        .en_i(1'b1),
        .match_o(dlc_ok)
    );

    // data byte seven, only when the payload reaches it
    swkf_field_cmp #(.W(8)) u_cmp_b7 (
        .rx_i(rx_frame_i.byte_seven),
        .exp_i(byte_seven_ff),
        .mask_i(8'hff),
        .en_i(b7_en),
        .match_o(b7_ok)
    );

    // data byte six, only when the payload reaches it
    swkf_field_cmp #(.W(8)) u_cmp_b6 (
        .rx_i(rx_frame_i.byte_six),
        .exp_i(byte_six_ff),
        .mask_i(8'hff),
        .en_i(b6_en),
        .match_o(b6_ok)
    );

    // read multiplexer; reserved bits and unmapped addresses give zero
    always_comb begin
        case (reg_req_i.addr)
            SWKF_ADDR_MASK_MID_HIGH: rd_mux = mask_high_ff;
            SWKF_ADDR_MASK_MID_LOW: rd_mux = mask_low_ff;
            SWKF_ADDR_MASK_LOWEST: begin
                rd_mux = {1'b0, mask_lowest_ff, 2'b00};
            end
            SWKF_ADDR_LENGTH_CODE: rd_mux = {4'h0, dlc_ff};
            SWKF_ADDR_BYTE_SEVEN: rd_mux = byte_seven_ff;
            SWKF_ADDR_BYTE_SIX: rd_mux = byte_six_ff;
            default: rd_mux = SWKF_RST_BYTE;
        endcase
    end

    // next state of every register
    always_comb begin
        nxt_mask_high = mask_high_ff;
        nxt_mask_low = mask_low_ff;
        nxt_mask_lowest = mask_lowest_ff;
        nxt_dlc = dlc_ff;
        nxt_byte_seven = byte_seven_ff;
        nxt_byte_six = byte_six_ff;
        nxt_rd_data = rd_data_ff;
        nxt_flag = flag_ff;
        nxt_match = 1'b0;
        wr_hit = 1'b0;
        if (soft_rst_i) begin
            // soft reset clears like power-on; flag too
            nxt_mask_high = SWKF_RST_BYTE;
            nxt_mask_low = SWKF_RST_BYTE;
            nxt_mask_lowest = SWKF_RST_LOWEST;
            nxt_dlc = SWKF_RST_DLC;
            nxt_byte_seven = SWKF_RST_BYTE;
            nxt_byte_six = SWKF_RST_BYTE;
            nxt_rd_data = SWKF_RST_BYTE;
            nxt_flag = 1'b0;
        end else begin
            // register writes; reserved bits are simply not stored
            if (reg_req_i.wr_en) begin
                wr_hit = 1'b1;
                case (reg_req_i.addr)
                    SWKF_ADDR_MASK_MID_HIGH: begin
                        nxt_mask_high = reg_req_i.wdata;
                    end
                    SWKF_ADDR_MASK_MID_LOW: begin
                        nxt_mask_low = reg_req_i.wdata;
                    end
                    SWKF_ADDR_MASK_LOWEST: begin
                        nxt_mask_lowest = reg_req_i.wdata[
                            SWKF_LOWEST_MSB:SWKF_LOWEST_LSB];
                    end
                    SWKF_ADDR_LENGTH_CODE: begin
                        nxt_dlc = reg_req_i.wdata[SWKF_DLC_MSB:0];
                    end
                    SWKF_ADDR_BYTE_SEVEN: begin
                        nxt_byte_seven = reg_req_i.wdata;
                    end
                    SWKF_ADDR_BYTE_SIX: begin
                        nxt_byte_six = reg_req_i.wdata;
                    end
                    default: begin
                        wr_hit = 1'b0; // not ours, no effect
                    end
                endcase
            end
            // read answer is held until the next read
            if (reg_req_i.rd_en) begin
                nxt_rd_data = rd_mux;
            end
            // host validates, then sets the flag
            if (cfg_valid_set_i) begin
                nxt_flag = 1'b1;
            end
            // clearing wins: a config touched with the set is stale
            if (wake_event_i || wr_hit || cfg_other_write_i) begin
                nxt_flag = 1'b0;
            end
            // wake only while validated and every field agrees
            nxt_match = frame_valid_i && flag_ff && id_ok && dlc_ok
                && b7_ok && b6_ok;
        end
    end

    // registers only; power-on reset takes constants
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_high_ff <= SWKF_RST_BYTE;
            mask_low_ff <= SWKF_RST_BYTE;
            mask_lowest_ff <= SWKF_RST_LOWEST;
            dlc_ff <= SWKF_RST_DLC;
            byte_seven_ff <= SWKF_RST_BYTE;
            byte_six_ff <= SWKF_RST_BYTE;
            rd_data_ff <= SWKF_RST_BYTE;
            flag_ff <= 1'b0;
            match_ff <= 1'b0;
        end else begin
            mask_high_ff <= nxt_mask_high;
            mask_low_ff <= nxt_mask_low;
            mask_lowest_ff <= nxt_mask_lowest;
            dlc_ff <= nxt_dlc;
            byte_seven_ff <= nxt_byte_seven;
            byte_six_ff <= nxt_byte_six;
            rd_data_ff <= nxt_rd_data;
            flag_ff <= nxt_flag;
            match_ff <= nxt_match;
        end
    end

    // outputs straight from flip-flops
    assign rd_data_o = rd_data_ff;
    assign config_valid_flag_o = flag_ff;
    assign wake_frame_match_o = match_ff;

    // helper copies for the checks below
    logic [SWKF_ID_W-1:0] chk_rx_id, chk_exp_id, chk_mask;
    logic [3:0] chk_rx_dlc;
    logic [7:0] chk_rx_b7;
    always_ff @(posedge clk_sys_i) begin
        chk_rx_id <= rx_frame_i.id;
        chk_exp_id <= exp_id_i;
        chk_mask <= id_mask;
        chk_rx_dlc <= rx_frame_i.dlc;
        chk_rx_b7 <= rx_frame_i.byte_seven;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    chk_mask_high_wr: assert property (
        reg_req_i.wr_en && !soft_rst_i
        && reg_req_i.addr == SWKF_ADDR_MASK_MID_HIGH
        |=> mask_high_ff == $past(reg_req_i.wdata))
        else $error("mask high not written");
    chk_mask_low_wr: assert property (
        reg_req_i.wr_en && !soft_rst_i
        && reg_req_i.addr == SWKF_ADDR_MASK_MID_LOW
        |=> mask_low_ff == $past(reg_req_i.wdata))
        else $error("mask low not written");
    chk_lowest_read: assert property (
        reg_req_i.wr_en && !soft_rst_i
        && reg_req_i.addr == SWKF_ADDR_MASK_LOWEST
        ##1 reg_req_i.rd_en && !soft_rst_i && !reg_req_i.wr_en
        && reg_req_i.addr == SWKF_ADDR_MASK_LOWEST
        |=> rd_data_o[6:2] == $past(reg_req_i.wdata[6:2], 2))
        else $error("lowest mask field lost");
    chk_reserved_zero: assert property (
        reg_req_i.rd_en && (reg_req_i.addr == SWKF_ADDR_MASK_LOWEST
        || reg_req_i.addr == SWKF_ADDR_LENGTH_CODE)
        |=> rd_data_o[7] == 1'b0 && (rd_data_o[1:0] == 2'b00
        || $past(reg_req_i.addr) == SWKF_ADDR_LENGTH_CODE)
        && (rd_data_o[6:4] == 3'b000
        || $past(reg_req_i.addr) == SWKF_ADDR_MASK_LOWEST))
        else $error("reserved bit read as one");
    chk_dlc_wr: assert property (
        reg_req_i.wr_en && !soft_rst_i
        && reg_req_i.addr == SWKF_ADDR_LENGTH_CODE
        |=> dlc_ff == $past(reg_req_i.wdata[3:0]))
        else $error("length code not written");
    chk_soft_clear: assert property (
        soft_rst_i |=> dlc_ff == 4'h0 && mask_high_ff == 8'h00
        && mask_low_ff == 8'h00 && mask_lowest_ff == 5'h00
        && byte_seven_ff == 8'h00 && byte_six_ff == 8'h00 && !flag_ff)
        else $error("soft reset left state");
    chk_flag_clear: assert property (
        wake_event_i || cfg_other_write_i || (reg_req_i.wr_en
        && reg_req_i.addr inside {[SWKF_ADDR_MASK_MID_HIGH:
        SWKF_ADDR_BYTE_SIX]}) |=> !config_valid_flag_o)
        else $error("valid flag not cleared");
    chk_match_dlc: assert property (
        wake_frame_match_o |-> chk_rx_dlc == $past(dlc_ff))
        else $error("match with differing length code");
    chk_match_id: assert property (
        wake_frame_match_o |-> ((chk_rx_id ^ chk_exp_id) & chk_mask) == '0
        && $past(config_valid_flag_o))
        else $error("match with differing identifier");
    chk_long_byte: assert property (
        wake_frame_match_o && chk_rx_dlc[3]
        |-> chk_rx_b7 == $past(byte_seven_ff))
        else $error("eight-byte match ignored byte seven");
    chk_byte_regs: assert property (
        reg_req_i.wr_en && !soft_rst_i
        && reg_req_i.addr == SWKF_ADDR_BYTE_SIX
        |=> byte_six_ff == $past(reg_req_i.wdata)
        && $stable(byte_seven_ff))
        else $error("byte six write wrong");
    chk_byte7_wr: assert property (
        reg_req_i.wr_en && !soft_rst_i
        && reg_req_i.addr == SWKF_ADDR_BYTE_SEVEN
        |=> byte_seven_ff == $past(reg_req_i.wdata)
        && $stable(byte_six_ff))
        else $error("byte seven write wrong");

endmodule // swkf_filter_cfg

// [rtl/swkf_pkg.sv]
package swkf_pkg;

    // register addresses on the serial register port (7-bit address)
    localparam logic [6:0] SWKF_ADDR_MASK_MID_HIGH = 7'h28;
    localparam logic [6:0] SWKF_ADDR_MASK_MID_LOW = 7'h29;
    localparam logic [6:0] SWKF_ADDR_MASK_LOWEST = 7'h2a;
    localparam logic [6:0] SWKF_ADDR_LENGTH_CODE = 7'h2b;
    localparam logic [6:0] SWKF_ADDR_BYTE_SEVEN = 7'h2c;
    localparam logic [6:0] SWKF_ADDR_BYTE_SIX = 7'h2d;

    // values after power-on or soft reset
    localparam logic [7:0] SWKF_RST_BYTE = 8'h00;
    localparam logic [4:0] SWKF_RST_LOWEST = 5'h00;
    localparam logic [3:0] SWKF_RST_DLC = 4'h0;

    // field positions
    localparam int SWKF_LOWEST_MSB = 6; // id mask bits 4..0 sit at 6:2
    localparam int SWKF_LOWEST_LSB = 2;
    localparam int SWKF_DLC_MSB = 3; // length code sits at 3:0
    localparam int SWKF_ID_W = 21; // identifier bits 20..0 handled here

    // length codes
    localparam logic [3:0] SWKF_DLC_SEVEN = 4'h7; // seven-byte payload

    // one access from the serial register decoder
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [6:0] addr;
        logic [7:0] wdata;
    } swkf_reg_req_type;

    // received frame fields presented by the receiver
    typedef struct packed {
        logic [SWKF_ID_W-1:0] id;
        logic [3:0] dlc;
        logic [7:0] byte_seven;
        logic [7:0] byte_six;
    } swkf_rx_frame_type;

endpackage

// [tb/swkf_filter_cfg_tb.sv]
`timescale 1ns/1ps
// register, flag and frame-compare checks of the wake filter setup
module swkf_filter_cfg_tb;
    import swkf_pkg::*;
    // one register row: address, value written, value read back
    typedef struct {
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } swkf_row_type;
    logic clk_sys_i = 1'b0; // 100 MHz
    logic nrst_i = 1'b0; // power-on reset asserted at start
    logic soft_rst_i = 1'b0;
    logic cfg_other_write_i = 1'b0;
    logic wake_event_i = 1'b0;
    logic frame_valid_i = 1'b0;
    logic [20:0] exp_id_i = 21'h1_2345; // expected identifier
    swkf_rx_frame_type rx_frame_i = '0;
    swkf_reg_req_type reg_req_i;
    logic cfg_valid_set_i;
    logic [7:0] rd_data_o;
    logic config_valid_flag_o;
    logic wake_frame_match_o;
    int n_mismatch = 0;
    int num_checks = 0;
    // last row is unmapped: ignored write, reads zero
    swkf_row_type rows[7] = '{'{7'h28, 8'ha5, 8'ha5}, '{7'h29, 8'h5a, 8'h5a},
        '{7'h2a, 8'hff, 8'h7c}, '{7'h2b, 8'hff, 8'h0f},
        '{7'h2c, 8'h81, 8'h81}, '{7'h2d, 8'h3c, 8'h3c},
        '{7'h30, 8'hff, 8'h00}};
    always #5 clk_sys_i = ~clk_sys_i;
    swkf_host_model host (.clk_sys_i(clk_sys_i), .reg_req_o(reg_req_i),
        .cfg_valid_set_o(cfg_valid_set_i));
    swkf_filter_cfg uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .soft_rst_i(soft_rst_i), .reg_req_i(reg_req_i),
        .rd_data_o(rd_data_o), .cfg_valid_set_i(cfg_valid_set_i),
        .cfg_other_write_i(cfg_other_write_i), .wake_event_i(wake_event_i),
        .exp_id_i(exp_id_i), .frame_valid_i(frame_valid_i),
        .rx_frame_i(rx_frame_i), .config_valid_flag_o(config_valid_flag_o),
        .wake_frame_match_o(wake_frame_match_o));
    // verdict and end of run, shared with the watchdog
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: byte got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: bit got %b want %b", $time, g, e);
        end
    endtask
    // read answer is registered at the taking edge, so seen 1 ns later
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        host.access(1'b0, 1'b1, a, 8'h00);
        chk8(rd_data_o, e);
    endtask
    // write, then see the flag one edge later
    task automatic wr_chk(input logic [6:0] a, input logic [7:0] d,
        input logic f);
        host.access(1'b1, 1'b0, a, d);
        chk1(config_valid_flag_o, f);
    endtask
    // one frame; the match output must equal m for one cycle, then be low
    task automatic frame(input logic [20:0] id, input logic [3:0] dlc,
        input logic [7:0] b7, input logic [7:0] b6, input logic m);
        rx_frame_i = '{id: id, dlc: dlc, byte_seven: b7, byte_six: b6};
        frame_valid_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        frame_valid_i = 1'b0;
        rx_frame_i = ~rx_frame_i; // fields no longer valid
        chk1(wake_frame_match_o, m);
        @(posedge clk_sys_i);
        #1;
        chk1(wake_frame_match_o, 1'b0);
    endtask
    // external clear sources: wake event or other config write
    task automatic strobe(input logic w, input logic o);
        wake_event_i = w;
        cfg_other_write_i = o;
        @(posedge clk_sys_i);
        #1;
        wake_event_i = 1'b0;
        cfg_other_write_i = 1'b0;
        chk1(config_valid_flag_o, 1'b0);
    endtask
    // watchdog far beyond the hundred or fewer cycles the run needs
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk1(config_valid_flag_o, 1'b0);
        nrst_i = 1'b1;
        foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
        foreach (rows[i]) begin
            wr_chk(rows[i].a, rows[i].d, 1'b0);
            rd_chk(rows[i].a, rows[i].e);
        end
        // mask: 20..13 and 4..0 compared, 12..5 ignored; length eight
        wr_chk(7'h28, 8'hff, 1'b0);
        wr_chk(7'h29, 8'h00, 1'b0);
        wr_chk(7'h2a, 8'h7c, 1'b0);
        wr_chk(7'h2b, 8'h08, 1'b0);
        host.set_valid();
        chk1(config_valid_flag_o, 1'b1);
        frame(21'h1_2345, 4'h8, 8'h81, 8'h3c, 1'b1);
        frame(21'h1_2345 ^ 21'h0_1fe0, 4'h8, 8'h81, 8'h3c, 1'b1);
        frame(21'h1_2345 ^ 21'h0_2000, 4'h8, 8'h81, 8'h3c, 1'b0);
        frame(21'h1_2345 ^ 21'h0_0001, 4'h8, 8'h81, 8'h3c, 1'b0);
        frame(21'h1_2345, 4'h9, 8'h81, 8'h3c, 1'b0);
        frame(21'h1_2345, 4'h8, 8'h80, 8'h3c, 1'b0);
        frame(21'h1_2345, 4'h8, 8'h81, 8'h3d, 1'b0);
        // seven bytes: byte seven not covered, byte six is
        wr_chk(7'h2b, 8'h07, 1'b0);
        frame(21'h1_2345, 4'h7, 8'h81, 8'h3c, 1'b0);
        host.set_valid();
        frame(21'h1_2345, 4'h7, 8'h00, 8'h3c, 1'b1);
        frame(21'h1_2345, 4'h7, 8'h81, 8'h00, 1'b0);
        wr_chk(7'h2b, 8'h00, 1'b0);
        host.set_valid();
        frame(21'h1_2345, 4'h0, 8'h00, 8'h00, 1'b1);
        // a long code other than eight still covers byte seven
        wr_chk(7'h2b, 8'h0f, 1'b0);
        host.set_valid();
        frame(21'h1_2345, 4'hf, 8'h81, 8'h3c, 1'b1);
        frame(21'h1_2345, 4'hf, 8'h80, 8'h3c, 1'b0);
        strobe(1'b1, 1'b0);
        host.set_valid();
        strobe(1'b0, 1'b1);
        host.set_valid();
        wr_chk(7'h30, 8'h55, 1'b1);
        wr_chk(7'h2c, 8'h81, 1'b0);
        host.set_valid();
        // set and wake in one cycle: the clear wins, config is stale
        fork
            host.set_valid();
            begin
                @(posedge clk_sys_i);
                #1;
                strobe(1'b1, 1'b0);
            end
        join
        // soft reset wipes every field and the flag
        soft_rst_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        soft_rst_i = 1'b0;
        chk1(config_valid_flag_o, 1'b0);
        foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
        // power-on reset in mid-run clears a fresh value too
        wr_chk(7'h2d, 8'h99, 1'b0);
        nrst_i = 1'b0;
        #20;
        nrst_i = 1'b1;
        rd_chk(7'h2d, 8'h00);
        host.idle();
        complete_run();
    end
endmodule // swkf_filter_cfg_tb

// [tb/swkf_host_model.sv]
`timescale 1ns/1ps
// host side of the register port; changes its requests 1 ns after an edge
module swkf_host_model (
    input wire logic clk_sys_i, // system clock
    output swkf_pkg::swkf_reg_req_type reg_req_o, // register access
    output logic cfg_valid_set_o // valid flag set pulse
);
    import swkf_pkg::*;
    // one access held across exactly one rising edge; the caller decides
    // what follows, so a back-to-back access never double-drives a step
    task automatic access(input logic w, input logic r,
        input logic [6:0] a, input logic [7:0] d);
        reg_req_o = '{wr_en: w, rd_en: r, addr: a, wdata: d};
        @(posedge clk_sys_i);
        #1;
    endtask
    // a released bus shows the inverse of the last values, never stale ones
    task automatic idle();
        access(1'b0, 1'b0, ~reg_req_o.addr, ~reg_req_o.wdata);
    endtask
    // host enables selective wake after one idle bus cycle, without reading back its setup
    task automatic set_valid();
        idle(); // a held write would clear the flag again
        cfg_valid_set_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        cfg_valid_set_o = 1'b0;
    endtask
    // quiet bus from time zero
    initial begin
        reg_req_o = '0;
        cfg_valid_set_o = 1'b0;
    end
endmodule // swkf_host_model
